// >>> design/psp_port.sv
// Serial program port: link-side shifter plus system-side register commit.
// Assumes link_sclk stops outside frames and the host honours select timing.
`timescale 1ns/1ps
module psp_port #(
  parameter int SHIFT_LEN = psp_pkg::SHIFT_W,
  parameter int CNT_LEN = psp_pkg::COUNT_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic link_sclk,
  input wire logic port_select_n,
  input wire logic serial_data,
  input wire logic ref_tick,
  input wire logic vco_tick,
  output logic gen_out,
  output logic drain_out,
  output logic drain_oe,
  output logic [psp_pkg::MODE_W-1:0] ref_mode,
  output logic [psp_pkg::REF_DIV_W-1:0] ref_divide,
  output logic [psp_pkg::CFG_W-1:0] config_value,
  output logic [psp_pkg::LOOP_W-1:0] loop_value
);

  // Refuse sizes the fixed field layout cannot serve
  if (SHIFT_LEN != psp_pkg::SHIFT_W || CNT_LEN != psp_pkg::COUNT_W) begin : g_bad_size
    $error("psp_port: shifter and counter sizes are fixed by the field layout");
  end

  // Saturating decrement, shared by both monitor dividers
  function automatic logic [psp_pkg::LOOP_DIV_W-1:0] ratio_last(input logic [psp_pkg::LOOP_DIV_W-1:0] r);
    ratio_last = (r == '0) ? '0 : r - 1'b1;
  endfunction

  // ---------------- Link domain ----------------

  // Set while select is high; first clock of a frame clears it
  logic fresh_reg;
  // Shifted data, most recent bit at the bottom
  logic [psp_pkg::SHIFT_W-1:0] shift_reg;
  logic [psp_pkg::SHIFT_W-1:0] shift_next;
  // Clocks seen in this frame, saturating
  logic [psp_pkg::COUNT_W-1:0] count_reg;
  logic [psp_pkg::COUNT_W-1:0] count_next;
  // Half stage feeding cascade data out
  logic cascade_reg;

  // New frame starts a clean word, else shift left
  assign shift_next = fresh_reg ? {{(psp_pkg::SHIFT_W-1){1'b0}}, serial_data}
                                : {shift_reg[psp_pkg::SHIFT_W-2:0], serial_data}; // [RL1] [RL7]
  // Count restarts at one on the first clock of a frame
  assign count_next = fresh_reg ? psp_pkg::LEN_ONE
                    : (count_reg == psp_pkg::LEN_MAX) ? count_reg : count_reg + 1'b1;

  // Select high forces the initialized state whatever the clock does
  always_ff @(posedge link_sclk or posedge port_select_n) begin
    if (port_select_n) begin
      fresh_reg <= 1'b1; // [RL10] [RL12]
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // Shift on rising clock only inside a frame
  always_ff @(posedge link_sclk) begin
    if (!port_select_n) begin
      shift_reg <= shift_next; // [RL1] [RL9] [RL10]
      count_reg <= count_next;
    end
  end

  // Top bit moves to cascade output on falling clock
  always_ff @(negedge link_sclk) begin
    cascade_reg <= shift_reg[psp_pkg::SHIFT_W-1]; // [RL8] [RL9]
  end

  // ---------------- Crossing ----------------

  // Bundle of link state seen by the system domain
  psp_pkg::psp_link_s link_raw;
  psp_pkg::psp_link_s link_sync;
  logic [psp_pkg::LINK_W-1:0] link_sync_bits;

  assign link_raw.sel_n = port_select_n;
  assign link_raw.fresh = fresh_reg;
  assign link_raw.count = count_reg;
  assign link_raw.data = shift_reg;
  assign link_raw.cascade = cascade_reg;
  assign link_sync = psp_pkg::psp_link_s'(link_sync_bits);

  // Count and data are frozen while select is high, so they settle before commit
  psp_sync #(
    .W(psp_pkg::LINK_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(link_raw),
    .sync_out(link_sync_bits)
  );

  // ---------------- System domain ----------------

  // Previous synchronised select, for rise detection
  logic sel_prev_reg;
  // Registered select rise; the commit waits one cycle for settled data
  logic commit_reg;
  // Set once a link clock was seen inside the current frame
  logic framed_reg;
  // Register file
  logic [psp_pkg::CFG_W-1:0] cfg_reg;
  logic [psp_pkg::CFG_W-1:0] cfg_next;
  logic [psp_pkg::REF_W-1:0] ref_buf1_reg;
  logic [psp_pkg::REF_W-1:0] ref_buf1_next;
  logic [psp_pkg::REF_DIV_W-1:0] ref_buf2_reg;
  logic [psp_pkg::REF_DIV_W-1:0] ref_buf2_next;
  logic [psp_pkg::LOOP_W-1:0] loop_reg;
  logic [psp_pkg::LOOP_W-1:0] loop_next;

  // Select edges as seen in the system domain
  wire sel_rise = link_sync.sel_n && !sel_prev_reg;
  wire sel_fall = !link_sync.sel_n && sel_prev_reg;
  // Fresh rises together with select, so remember the clocks before it does
  // A clock seen in the same cycle as the select fall wins over the clear
  wire framed_next = (!link_sync.sel_n && !link_sync.fresh) ? 1'b1 : sel_fall ? 1'b0 : framed_reg;

  // Commit decode, one cycle after the select rise so count and data have settled
  wire commit = commit_reg;
  wire hit_cfg = commit && framed_reg && link_sync.count == psp_pkg::LEN_CFG;
  wire hit_ref = commit && framed_reg && link_sync.count == psp_pkg::LEN_REF;
  wire hit_loop = commit && framed_reg && link_sync.count == psp_pkg::LEN_LOOP;
  wire hit_empty = commit && !framed_reg;
  wire copy_ref = hit_loop || hit_empty;

  // Next values; every other length leaves all three untouched
  assign cfg_next = hit_cfg ? link_sync.data[psp_pkg::CFG_W-1:0] : cfg_reg; // [RL2] [RL3] [RL23]
  assign ref_buf1_next = hit_ref ? link_sync.data[psp_pkg::REF_W-1:0] : ref_buf1_reg; // [RL2] [RL3] [RL23]
  assign loop_next = hit_loop ? link_sync.data : loop_reg; // [RL2] [RL3] [RL23]
  assign ref_buf2_next = copy_ref ? ref_buf1_reg[psp_pkg::REF_DIV_W-1:0] : ref_buf2_reg; // [RL4] [RL5] [RL6]

  // Select edge tracker
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sel_prev_reg <= 1'b1;
      commit_reg <= 1'b0;
      framed_reg <= 1'b0;
    end else begin
      sel_prev_reg <= link_sync.sel_n;
      commit_reg <= sel_rise; // [RL3]
      framed_reg <= framed_next; // [RL6]
    end
  end

  // Register file update
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_reg <= psp_pkg::CFG_RESET;
      ref_buf1_reg <= psp_pkg::REF_RESET;
      ref_buf2_reg <= psp_pkg::REF_RESET[psp_pkg::REF_DIV_W-1:0];
      loop_reg <= psp_pkg::LOOP_RESET; // [RL17]
    end else begin
      cfg_reg <= cfg_next;
      ref_buf1_reg <= ref_buf1_next;
      ref_buf2_reg <= ref_buf2_next;
      loop_reg <= loop_next;
    end
  end

  // ---------------- Monitor dividers ----------------

  // Reference monitor counter
  logic [psp_pkg::REF_DIV_W-1:0] ref_cnt_reg;
  logic [psp_pkg::REF_DIV_W-1:0] ref_cnt_next;
  logic ref_mon_reg;
  // Loop monitor counter
  logic [psp_pkg::LOOP_DIV_W-1:0] loop_cnt_reg;
  logic [psp_pkg::LOOP_DIV_W-1:0] loop_cnt_next;
  logic loop_mon_reg;

  // Ratio from the double-buffered field; zero and one pass every tick
  wire [psp_pkg::LOOP_DIV_W-1:0] ref_last =
    ratio_last({{(psp_pkg::LOOP_DIV_W-psp_pkg::REF_DIV_W){1'b0}}, ref_buf2_reg}); // [RL15]
  wire ref_wrap = ref_tick && ({{(psp_pkg::LOOP_DIV_W-psp_pkg::REF_DIV_W){1'b0}}, ref_cnt_reg} >= ref_last);
  assign ref_cnt_next = !ref_tick ? ref_cnt_reg : ref_wrap ? '0 : ref_cnt_reg + 1'b1;

  // Main*64 plus swallow equals the low 18 loop bits read as one number
  wire [psp_pkg::LOOP_DIV_W-1:0] loop_last = ratio_last(loop_reg[psp_pkg::LOOP_DIV_W-1:0]); // [RL16]
  wire loop_wrap = vco_tick && (loop_cnt_reg >= loop_last);
  assign loop_cnt_next = !vco_tick ? loop_cnt_reg : loop_wrap ? '0 : loop_cnt_reg + 1'b1;

  // Normally low monitors with one-cycle high pulses at ratios above one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ref_cnt_reg <= '0;
      loop_cnt_reg <= '0;
      ref_mon_reg <= 1'b0;
      loop_mon_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
      loop_cnt_reg <= loop_cnt_next;
      ref_mon_reg <= ref_wrap; // [RL15]
      loop_mon_reg <= loop_wrap; // [RL16]
    end
  end

  // ---------------- Outputs ----------------

  // Source select from the loop register top bits
  wire [1:0] out_src = {loop_reg[psp_pkg::OUT_SEL_HI], loop_reg[psp_pkg::OUT_SEL_LO]};
  logic gen_next;
  always_comb begin
    unique case (out_src)
      psp_pkg::SRC_REF_MON: gen_next = ref_mon_reg; // [RL14]
      psp_pkg::SRC_LOOP_MON: gen_next = loop_mon_reg; // [RL14]
      psp_pkg::SRC_CASCADE: gen_next = link_sync.cascade; // [RL8] [RL14]
      psp_pkg::SRC_PORT: gen_next = cfg_reg[psp_pkg::CFG_PORT_BIT]; // [RL18]
    endcase
  end

  // Drain pulls low while its bit is zero
  wire drain_oe_next = !cfg_reg[psp_pkg::CFG_DRAIN_BIT]; // [RL19]

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gen_out <= 1'b0;
      drain_out <= 1'b0;
      drain_oe <= 1'b1; // [RL20]
      ref_mode <= '0;
      ref_divide <= '0;
      config_value <= psp_pkg::CFG_RESET;
      loop_value <= psp_pkg::LOOP_RESET;
    end else begin
      gen_out <= gen_next;
      drain_out <= 1'b0;
      drain_oe <= drain_oe_next;
      ref_mode <= ref_buf1_reg[psp_pkg::REF_W-1:psp_pkg::REF_MODE_LSB]; // [RL4] [RL22]
      ref_divide <= ref_buf2_reg;
      config_value <= cfg_reg;
      loop_value <= loop_reg;
    end
  end

  // ---------------- Checks ----------------

  // A commit one cycle before its register update
  sequence commit_len(logic [psp_pkg::COUNT_W-1:0] n);
    commit && framed_reg && link_sync.count == n;
  endsequence

  // Config takes the low byte of the shifted word
  chk_cfg_load: assert property (@(posedge clk_sys) disable iff (reset) // [RL2]
    commit_len(psp_pkg::LEN_CFG) |=> cfg_reg == $past(link_sync.data[psp_pkg::CFG_W-1:0]))
    else $error("config not loaded on 8-bit commit");

  // Reference buffer one takes the low half word
  chk_ref_load: assert property (@(posedge clk_sys) disable iff (reset) // [RL2]
    commit_len(psp_pkg::LEN_REF) |=> ref_buf1_reg == $past(link_sync.data[psp_pkg::REF_W-1:0]))
    else $error("reference buffer not loaded on 16-bit commit");

  // Loop write also moves the reference buffer
  chk_loop_copy: assert property (@(posedge clk_sys) disable iff (reset) // [RL5]
    commit_len(psp_pkg::LEN_LOOP) |=> loop_reg == $past(link_sync.data)
      && ref_buf2_reg == $past(ref_buf1_reg[psp_pkg::REF_DIV_W-1:0]))
    else $error("loop commit did not load loop and copy reference");

  // Empty select pulse copies the reference buffer only
  chk_empty_copy: assert property (@(posedge clk_sys) disable iff (reset) // [RL6]
    hit_empty |=> ref_buf2_reg == $past(ref_buf1_reg[psp_pkg::REF_DIV_W-1:0]) && $stable(loop_reg))
    else $error("empty select pulse did not copy reference");

  // Odd lengths change nothing
  chk_odd_len: assert property (@(posedge clk_sys) disable iff (reset) // [RL23]
    commit && framed_reg && !hit_cfg && !hit_ref && !hit_loop
      |=> $stable(cfg_reg) && $stable(ref_buf1_reg) && $stable(loop_reg) && $stable(ref_buf2_reg))
    else $error("odd length altered a register");

  // Without a commit the registers hold
  chk_hold_shift: assert property (@(posedge clk_sys) disable iff (reset) // [RL3]
    !commit |=> $stable(cfg_reg) && $stable(loop_reg) && $stable(ref_buf1_reg))
    else $error("register changed without commit");

  // Port mode output follows the port bit one cycle on
  chk_port_out: assert property (@(posedge clk_sys) disable iff (reset) // [RL18]
    out_src == psp_pkg::SRC_PORT ##1 out_src == psp_pkg::SRC_PORT
      |=> gen_out == $past(cfg_reg[psp_pkg::CFG_PORT_BIT]))
    else $error("port output does not follow port bit");

  // Drain enable is the inverse of its bit, one cycle later
  chk_drain_lvl: assert property (@(posedge clk_sys) disable iff (reset) // [RL19]
    ##1 drain_oe == !$past(cfg_reg[psp_pkg::CFG_DRAIN_BIT]) && !drain_out)
    else $error("drain output does not follow its bit");

  // Reference monitor pulses are single cycles
  chk_ref_pulse: assert property (@(posedge clk_sys) disable iff (reset) // [RL15]
    ref_mon_reg && ref_buf2_reg > 13'h0001 |=> !ref_mon_reg)
    else $error("reference monitor pulse too long");

  // First cycle after reset pulls the drain low and selects cascade
  chk_reset_val: assert property (@(posedge clk_sys) // [RL17] [RL20]
    $fell(reset) |-> drain_oe && out_src == psp_pkg::SRC_CASCADE)
    else $error("reset values wrong");

  // A clock inside the frame marks it as carrying data
  chk_frame_flag: assert property (@(posedge clk_sys) disable iff (reset) // [RL6]
    !link_sync.sel_n && !link_sync.fresh |=> framed_reg)
    else $error("frame flag missed a link clock");

  // Config write leaves the other registers alone
  chk_cfg_side: assert property (@(posedge clk_sys) disable iff (reset) // [RL7]
    hit_cfg |=> $stable(ref_buf1_reg) && $stable(loop_reg) && $stable(ref_buf2_reg))
    else $error("config write touched another register");

  // Reference write leaves config, loop and second buffer alone
  chk_ref_side: assert property (@(posedge clk_sys) disable iff (reset) // [RL4] [RL7]
    hit_ref |=> $stable(cfg_reg) && $stable(loop_reg) && $stable(ref_buf2_reg))
    else $error("reference write touched another register");

  // Empty select pulse leaves config and buffer one alone
  chk_empty_keep: assert property (@(posedge clk_sys) disable iff (reset) // [RL6]
    hit_empty |=> $stable(cfg_reg) && $stable(ref_buf1_reg))
    else $error("empty select pulse touched a register");

  // Second buffer moves only on a copy
  chk_buf2_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    !copy_ref |=> $stable(ref_buf2_reg))
    else $error("second reference buffer changed without copy");

  // Upper reference bits reach their output one cycle later
  chk_ref_mode: assert property (@(posedge clk_sys) disable iff (reset) // [RL4] [RL22]
    ##1 ref_mode == $past(ref_buf1_reg[psp_pkg::REF_W-1:psp_pkg::REF_MODE_LSB]))
    else $error("reference mode does not follow buffer one");

  // Divide ratio output follows the second buffer
  chk_divide_out: assert property (@(posedge clk_sys) disable iff (reset) // [RL4]
    ##1 ref_divide == $past(ref_buf2_reg))
    else $error("divide output does not follow second buffer");

  // Reference monitor source shows its pulse one cycle later
  chk_ref_src: assert property (@(posedge clk_sys) disable iff (reset) // [RL14] [RL15]
    out_src == psp_pkg::SRC_REF_MON |=> gen_out == $past(ref_mon_reg))
    else $error("general output does not show reference monitor");

  // Loop monitor source shows its pulse one cycle later
  chk_loop_src: assert property (@(posedge clk_sys) disable iff (reset) // [RL14] [RL16]
    out_src == psp_pkg::SRC_LOOP_MON |=> gen_out == $past(loop_mon_reg))
    else $error("general output does not show loop monitor");

  // Loop monitor pulses are single cycles
  chk_loop_pulse: assert property (@(posedge clk_sys) disable iff (reset) // [RL16]
    loop_mon_reg && loop_reg[psp_pkg::LOOP_DIV_W-1:0] > 18'h00001 |=> !loop_mon_reg)
    else $error("loop monitor pulse too long");

endmodule

// >>> common/psp_pkg.sv
// Constants, field layouts and carrier types for the serial program port.
// Assumes a system clock domain and a serial clock domain owned by the host.
// Contract
// (RL1) Words arrive MSB first, sampled on rising clock.
// (RL2) Length 8/16/24 picks config/reference/loop register.
// (RL3) Registers change only when select rises.
// (RL4) Low 13 reference bits double-buffered, top 3 immediate.
// (RL5) Loop write copies reference buffer one into two.
// (RL6) Select pulse without clocks also copies buffers.
// (RL7) No address bits; any write order allowed.
// (RL8) Cascade out shifts on falling serial clock.
// (RL9) Static 24.5-stage shifter, any clock rate.
// (RL10) Select high ignores clocks, port stays initialized.
// (RL11) Host frames each transfer with select low.
// (RL12) Select changes only while clock low; resync.
// (RL13) Host keeps main count at least swallow count.
// (RL14) Loop top bits choose general output source.
// (RL15) Reference monitor pulses high, ratio from field.
// (RL16) Loop monitor divides by main*64 plus swallow.
// (RL17) Power-up selects cascade data out.
// (RL18) Port mode drives configuration port bit.
// (RL19) Drain output low when bit zero, else released.
// (RL20) Reset forces drain output low.
// (RL21) Host holds clock low or select high.
// (RL22) Upper reference bits set oscillator mode.
// (RL23) Other lengths leave all registers unchanged.
package psp_pkg;

  // Register widths
  localparam int CFG_W = 8;
  localparam int REF_W = 16;
  localparam int LOOP_W = 24;
  localparam int SHIFT_W = 24;
  localparam int COUNT_W = 6;
  localparam int REF_DIV_W = 13;
  localparam int LOOP_DIV_W = 18;
  localparam int MODE_W = 3;

  // Transfer lengths that select a register, then the count restart value and saturation limit
  localparam logic [COUNT_W-1:0] LEN_CFG = 6'h08;
  localparam logic [COUNT_W-1:0] LEN_REF = 6'h10;
  localparam logic [COUNT_W-1:0] LEN_LOOP = 6'h18;
  localparam logic [COUNT_W-1:0] LEN_ONE = 6'h01;
  localparam logic [COUNT_W-1:0] LEN_MAX = 6'h3f;

  // Field positions
  localparam int CFG_PORT_BIT = 1;
  localparam int CFG_DRAIN_BIT = 0;
  localparam int REF_MODE_LSB = 13;
  localparam int OUT_SEL_HI = 23;
  localparam int OUT_SEL_LO = 22;

  // General output source codes
  localparam logic [1:0] SRC_REF_MON = 2'h3;
  localparam logic [1:0] SRC_LOOP_MON = 2'h2;
  localparam logic [1:0] SRC_CASCADE = 2'h1;
  localparam logic [1:0] SRC_PORT = 2'h0;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [REF_W-1:0] REF_RESET = 16'h0000;
  localparam logic [LOOP_W-1:0] LOOP_RESET = 24'h400000;

  // Link state carried into the system domain
  typedef struct packed {
    logic sel_n;
    logic fresh;
    logic [COUNT_W-1:0] count;
    logic [SHIFT_W-1:0] data;
    logic cascade;
  } psp_link_s;

  localparam int LINK_W = $bits(psp_link_s);

endpackage

// >>> design/psp_sync.sv
// Two-stage synchroniser for a bundle of slow or quasi-static bits.
// Assumes the bundle is stable for several destination clocks.
`timescale 1ns/1ps
module psp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // First stage, read only by the second
  logic [W-1:0] meta_reg;

  // Two flops in series, set synchronously
  // Reset to ones so an idle-high select shows no false edge after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// >>> testbench/psp_host.sv
// Host model driving the serial program port: clock, select and data.
// Assumes the bench calls its tasks; link clock runs only inside bursts.
`timescale 1ns/1ps
module psp_host (
  output logic link_sclk,
  output logic port_select_n,
  output logic serial_data
);
  // Idle levels at power-up: clock low, select high
  initial begin
    link_sclk = 1'b0;
    port_select_n = 1'b1;
    serial_data = 1'b0;
  end

  // One framed transfer of n bits, MSB first, 6 ns link clock
  task automatic send(input logic [31:0] d, input int n);
    #1.7;
    port_select_n = 1'b0; // Select falls with clock low
    #60; // Select low long enough for the port to see it
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = d[i]; // Top bit first, stable over rising edge
      #3 link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
    end
    #3 port_select_n = 1'b1; // Commit with clock low
    serial_data = ~serial_data; // Released line does not hold its value
  endtask

  // Clock bursts while select stays high
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      serial_data = ~serial_data; // Changing pattern while idle
      #3 link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
    end
  endtask
endmodule

// >>> testbench/test_pll_serial_program_port.sv
// Self-checking bench for the serial program port.
// Assumes the host model drives the link; ticks come from the bench.
`timescale 1ns/1ps
module test_pll_serial_program_port;
  logic clk_sys; // System clock
  logic reset; // Synchronous reset
  logic ref_tick; // Reference period pulse
  logic vco_tick; // Prescaled RF pulse
  wire link_sclk; // Host clock
  wire port_select_n; // Host select
  wire serial_data; // Host data
  logic gen_out;
  logic drain_out;
  logic drain_oe;
  logic [psp_pkg::MODE_W-1:0] ref_mode;
  logic [psp_pkg::REF_DIV_W-1:0] ref_divide;
  logic [psp_pkg::CFG_W-1:0] config_value;
  logic [psp_pkg::LOOP_W-1:0] loop_value;
  int failures; // Mismatch count
  int check_count; // Comparison count
  logic [7:0] e_cfg; // Expected configuration
  logic [12:0] e_ref1; // Expected first reference buffer
  logic [12:0] e_ref2; // Expected second reference buffer
  logic [2:0] e_mode; // Expected immediate reference bits
  logic [23:0] e_loop; // Expected loop register
  int lens[8] = '{0, 8, 16, 24, 7, 12, 25, 32}; // Frame lengths used

  psp_host host (.link_sclk(link_sclk), .port_select_n(port_select_n), .serial_data(serial_data));

  psp_port dut (
    .clk_sys(clk_sys), .reset(reset), .link_sclk(link_sclk),
    .port_select_n(port_select_n), .serial_data(serial_data),
    .ref_tick(ref_tick), .vco_tick(vco_tick), .gen_out(gen_out),
    .drain_out(drain_out), .drain_oe(drain_oe), .ref_mode(ref_mode),
    .ref_divide(ref_divide), .config_value(config_value), .loop_value(loop_value)
  );

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Compare one value and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic close_out;
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Expected register update for a frame of n bits
  function automatic void model(input int n, input logic [31:0] d);
    if (n == 8) e_cfg = d[7:0];
    else if (n == 16) begin
      e_ref1 = d[12:0];
      e_mode = d[15:13];
    end else if (n == 24) begin
      e_loop = d[23:0];
      e_ref2 = e_ref1;
    end else if (n == 0) e_ref2 = e_ref1;
  endfunction

  // One frame, then hold check, commit and output checks
  task automatic step(input int n, input logic [31:0] d);
    host.send(d, n);
    @(negedge clk_sys);
    chk("loop_hold", loop_value, e_loop);
    chk("cfg_hold", config_value, e_cfg);
    model(n, d);
    repeat (8) @(negedge clk_sys);
    chk("config", config_value, e_cfg);
    chk("ref_mode", ref_mode, e_mode);
    chk("ref_divide", ref_divide, e_ref2);
    chk("loop", loop_value, e_loop);
    chk("drain_oe", drain_oe, !e_cfg[0]);
    chk("drain_out", drain_out, 1'b0);
    case (e_loop[23:22])
      psp_pkg::SRC_PORT: chk("port", gen_out, e_cfg[1]);
      psp_pkg::SRC_CASCADE: if (n >= 24) chk("cascade", gen_out, d[23]);
      default: chk("mon_idle", gen_out, 1'b0);
    endcase
  endtask

  // Tick every other cycle n times and count monitor pulses
  task automatic mon(input bit use_ref, input int n, input int exp);
    int c;
    c = 0;
    for (int i = 0; i < 2 * n + 8; i++) begin
      @(posedge clk_sys);
      ref_tick <= use_ref && (i % 2 == 0) && (i < 2 * n);
      vco_tick <= !use_ref && (i % 2 == 0) && (i < 2 * n);
      @(negedge clk_sys);
      if (gen_out === 1'b1) c++;
    end
    chk("mon_pulses", c, exp);
  endtask

  // Watchdog on the whole run
  initial begin
    #1000000;
    failures++;
    close_out();
  end

  // Main sequence
  initial begin
    int n;
    failures = 0;
    check_count = 0;
    reset = 1'b1;
    ref_tick = 1'b0;
    vco_tick = 1'b0;
    e_cfg = psp_pkg::CFG_RESET;
    e_ref1 = '0;
    e_ref2 = '0;
    e_mode = '0;
    e_loop = psp_pkg::LOOP_RESET;
    void'($urandom(44));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("rst_loop", loop_value, 24'h400000);
    chk("rst_oe", drain_oe, 1'b1);
    chk("rst_cfg", config_value, psp_pkg::CFG_RESET);
    host.idle_clocks(5); // Ignored while select high
    step(16, 32'h0000a005); // Second buffer must keep old ratio
    step(0, 32'h0); // Zero-clock select pulse
    step(24, 32'h00c000c2); // Main 3 not below swallow 2
    mon(1'b1, 20, 4);
    step(24, 32'h008000c2);
    mon(1'b0, 388, 2);
    for (int k = 0; k < 60; k++) begin
      if ($urandom_range(3) == 0) host.idle_clocks($urandom_range(4) + 1);
      n = lens[$urandom_range(7)];
      step(n, $urandom());
    end
    close_out();
  end
endmodule
